// ==== design/msr_pkg.sv ====
// msr_pkg: constants for the measurement start and read-out command block
package msr_pkg;

  // ------------------------------------------------------------------
  // command bytes (first byte of a frame)
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_CHIP_RESET   = 8'hF0;
  localparam logic [7:0] CMD_START_DIAG   = 8'hB0;
  localparam logic [7:0] CMD_START_READ   = 8'hC3;
  localparam logic [7:0] CMD_MEAS_MASK    = 8'hFC;
  localparam logic [7:0] CMD_MEAS_CODE    = 8'hD0;
  localparam int         CMD_OFFS_INV_POS = 1;
  localparam int         CMD_TEST_POS     = 0;

  // ------------------------------------------------------------------
  // option byte (second byte of a start-measurement frame)
  // ------------------------------------------------------------------
  localparam int OPT_SEQ_POS    = 7;
  localparam int OPT_FIRE_A_POS = 4;
  localparam int OPT_FIRE_B_POS = 3;
  localparam int OPT_ACT_A_POS  = 2;
  localparam int OPT_ACT_B_POS  = 1;

  // ------------------------------------------------------------------
  // status byte
  // ------------------------------------------------------------------
  localparam int STAT_INVALID_POS = 7;
  localparam int STAT_MODE_LSB    = 5;
  localparam int STAT_OSC_POS     = 1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;

  // ------------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------------
  localparam int FRAME_MAX   = 13;
  localparam int FRAME_HDR   = 2;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // ------------------------------------------------------------------
  // test pulse amplitudes in microamps
  // ------------------------------------------------------------------
  localparam logic [4:0] TEST_UA_0 = 5'h05;
  localparam logic [4:0] TEST_UA_1 = 5'h0D;
  localparam logic [4:0] TEST_UA_2 = 5'h15;
  localparam logic [4:0] TEST_UA_3 = 5'h1D;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ        = 20;
  localparam int SELECT_TO_READY_DELAY_NS     = 1000;
  localparam int CS_DR_CYC      = (SELECT_TO_READY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int T_SEQ1_MIN_US  = 520;
  localparam int T_SEQ2_MIN_US  = 786;
  localparam int T_DIAG_MIN_US  = 605;
  localparam int SEQ1_MIN_CYC   = T_SEQ1_MIN_US * CLK_MHZ;
  localparam int SEQ2_MIN_CYC   = T_SEQ2_MIN_US * CLK_MHZ;
  localparam int DIAG_MIN_CYC   = T_DIAG_MIN_US * CLK_MHZ;

  typedef enum logic [1:0] {
    MSR_IDLE    = 2'b00,
    MSR_DELAY   = 2'b01,
    MSR_CONVERT = 2'b10
  } msr_state_e;

endpackage

// ==== design/msr_measure_readout.sv ====
// msr_measure_readout: start-measurement / read-out command logic with spi link
//
// Notes on behaviour
// - sequence bit one: ambient C and D, die temperature, supply voltage
// - sequence bit zero: DC light, active light, LED temperature, pulse supply
// - sequence two: bit 4 fires LED A, bit 3 fires LED B
// - sequence two: bit 2 enables active channel A, bit 1 channel B
// - measurement starts only once chip select returns high
// - ready drops after fixed delay, rises when conversions and auto-zero finish
// - conversion time never shorter than the tabulated minimum
// - offset-invert bit flips ADC buffer offset sign for active channels
// - test bit injects internal current pulses; LED drivers stay off
// - test amplitude from fired channel level bits: 5, 13, 21, 29 uA
// - even parity over seven option bits; mismatch sets invalid flag
// - after start or diagnostics, only chip reset accepted until ready
// - start and diagnostics refused outside normal mode
// - read-out refused outside normal mode
// - all measurement data cleared when a read-out ends
// - sequence one frame: die temp, C, D, two reserved, supply, CRC
// - sequence two frame: DC A, DC B, supply, active A, B, LED temp
// - disabled measurements are dropped and later bytes close up
// - a CRC byte always ends the frame
// - first returned byte is status; top bit marks invalid last command
// - second returned byte echoes the first command byte
`timescale 1ns/1ps

module msr_measure_readout
  import msr_pkg::*;
#(
  parameter int SEQ1_MIN = msr_pkg::SEQ1_MIN_CYC,
  parameter int SEQ2_MIN = msr_pkg::SEQ2_MIN_CYC,
  parameter int DIAG_MIN = msr_pkg::DIAG_MIN_CYC,
  parameter logic [7:0] CRC_POLY = 8'h07
) (
  // system
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // spi link
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // ready pin
  output logic             data_ready_pin,
  // configuration and mode
  input  wire logic [1:0]  power_mode,
  input  wire logic        die_temp_gate,
  input  wire logic        ambient_c_gate,
  input  wire logic        ambient_d_gate,
  input  wire logic        supply_monitor_gate,
  input  wire logic        active_a_gate,
  input  wire logic        active_b_gate,
  input  wire logic        led_heat_sense_gate,
  input  wire logic        chan_a_level_high,
  input  wire logic        chan_a_level_low,
  input  wire logic        chan_b_level_high,
  input  wire logic        chan_b_level_low,
  // front end control
  output logic             meas_start,
  output logic             diag_start,
  output logic             seq_one,
  output logic             fire_led_a,
  output logic             fire_led_b,
  output logic             led_drive_a,
  output logic             led_drive_b,
  output logic             active_chan_a,
  output logic             active_chan_b,
  output logic             offset_invert,
  output logic             test_pulse,
  output logic [4:0]       test_current_ua,
  output logic             chip_reset_pulse,
  // front end results
  input  wire logic        conv_done,
  input  wire logic        autozero_busy,
  input  wire logic [15:0] res_die_temp,
  input  wire logic [15:0] res_amb_c,
  input  wire logic [15:0] res_amb_d,
  input  wire logic [15:0] res_reserved,
  input  wire logic [15:0] res_supply,
  input  wire logic [15:0] res_dc_a,
  input  wire logic [15:0] res_dc_b,
  input  wire logic [15:0] res_act_a,
  input  wire logic [15:0] res_act_b,
  input  wire logic [15:0] res_led_temp
);

  // ------------------------------------------------------------------
  // spi domain: capture command bytes, shift out reply
  // ------------------------------------------------------------------
  logic       spi_rst_n;
  logic [2:0] bit_cnt_q;
  logic [3:0] byte_cnt_q;
  logic [6:0] shift_in_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic       two_bytes_q;
  logic       extra_clk_q;
  logic [7:0] status_byte;
  logic [7:0] tx_byte;
  logic [7:0] frame_q [FRAME_MAX];
  logic [3:0] frame_len_q;
  logic [3:0] data_idx;
  logic       byte_end;

  // counters restart at every chip select low period
  assign spi_rst_n = resetn & ~spi_cs_n;
  assign byte_end  = (bit_cnt_q == 3'h7);
  assign data_idx  = byte_cnt_q - 4'(FRAME_HDR);

  always_ff @(posedge spi_sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 4'h0;
      shift_in_q <= 7'h00;
    end else begin
      bit_cnt_q  <= bit_cnt_q + 3'h1;
      shift_in_q <= {shift_in_q[5:0], spi_mosi};
      if (byte_end && byte_cnt_q != 4'hF) begin
        byte_cnt_q <= byte_cnt_q + 4'h1;
      end
    end
  end

  // command bytes survive chip select high so the system side can decode them
  always_ff @(posedge spi_sclk or negedge resetn) begin
    if (!resetn) begin
      ctrl1_q     <= 8'h00;
      ctrl2_q     <= 8'h00;
      two_bytes_q <= 1'b0;
      extra_clk_q <= 1'b0;
    end else if (byte_cnt_q == 4'h0) begin
      if (bit_cnt_q == 3'h0) begin
        two_bytes_q <= 1'b0;
        extra_clk_q <= 1'b0;
      end
      if (byte_end) begin
        ctrl1_q <= {shift_in_q, spi_mosi};
      end
    end else if (byte_cnt_q == 4'h1) begin
      if (byte_end) begin
        ctrl2_q     <= {shift_in_q, spi_mosi};
        two_bytes_q <= 1'b1;
      end
    end else begin
      extra_clk_q <= 1'b1;
    end
  end

  assign tx_byte = (byte_cnt_q == 4'h0) ? status_byte :
                   (byte_cnt_q == 4'h1) ? ctrl1_q :
                   (data_idx < frame_len_q) ? frame_q[data_idx] : 8'h00;
  assign spi_miso    = spi_cs_n ? 1'b0 : tx_byte[3'h7 - bit_cnt_q];
  assign spi_miso_oe = ~spi_cs_n;

  // ------------------------------------------------------------------
  // system domain: chip select synchroniser and command decode
  // ------------------------------------------------------------------
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic cs_rise;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else if (clk_en) begin
      cs_s1_q <= spi_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  assign cs_rise = clk_en & cs_s2_q & ~cs_s3_q & two_bytes_q;

  msr_state_e state_q;
  msr_state_e state_d;
  logic       busy;
  logic       normal_mode;
  logic       is_reset;
  logic       is_meas;
  logic       is_diag;
  logic       is_read;
  logic       parity_ok;
  logic       take_meas;
  logic       take_diag;
  logic       take_read;
  logic       reject;
  logic       readout_end;

  assign busy        = (state_q != MSR_IDLE);
  assign normal_mode = (power_mode == MODE_NORMAL);
  assign is_reset    = (ctrl1_q == CMD_CHIP_RESET);
  assign is_meas     = ((ctrl1_q & CMD_MEAS_MASK) == CMD_MEAS_CODE);
  assign is_diag     = (ctrl1_q == CMD_START_DIAG);
  assign is_read     = (ctrl1_q == CMD_START_READ);
  assign parity_ok   = ~(^ctrl2_q);
  assign take_meas   = cs_rise & is_meas & parity_ok & ~busy & normal_mode;
  assign take_diag   = cs_rise & is_diag & ~busy & normal_mode;
  assign take_read   = cs_rise & is_read & ~busy & normal_mode;
  assign reject      = cs_rise & ~is_reset & ctrl1_q[7] &
                       (busy | ((is_meas | is_diag | is_read) & ~normal_mode) |
                        (is_meas & ~parity_ok));
  assign readout_end = take_read | (take_meas & extra_clk_q);

  // ------------------------------------------------------------------
  // option latch and front end controls
  // ------------------------------------------------------------------
  logic [7:0] opt_q;
  logic       offs_inv_q;
  logic       test_q;
  logic       invalid_q;
  logic       diag_run_q;
  logic       start_q;
  logic       dstart_q;
  logic       creset_q;
  logic [1:0] level_sel;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      opt_q      <= 8'h00;
      offs_inv_q <= 1'b0;
      test_q     <= 1'b0;
      invalid_q  <= 1'b0;
      diag_run_q <= 1'b0;
      start_q    <= 1'b0;
      dstart_q   <= 1'b0;
      creset_q   <= 1'b0;
    end else if (clk_en) begin
      start_q  <= take_meas;
      dstart_q <= take_diag;
      creset_q <= cs_rise & is_reset;
      if (take_meas) begin
        opt_q      <= ctrl2_q;
        offs_inv_q <= ctrl1_q[CMD_OFFS_INV_POS];
        test_q     <= ctrl1_q[CMD_TEST_POS];
      end
      if (take_meas | take_diag) begin
        diag_run_q <= take_diag;
      end
      if (cs_rise && ctrl1_q[7]) begin
        invalid_q <= reject;
      end
    end
  end

  assign meas_start       = start_q;
  assign diag_start       = dstart_q;
  assign chip_reset_pulse = creset_q;
  assign seq_one       = opt_q[OPT_SEQ_POS];
  assign fire_led_a    = ~seq_one & opt_q[OPT_FIRE_A_POS];
  assign fire_led_b    = ~seq_one & opt_q[OPT_FIRE_B_POS];
  assign led_drive_a   = fire_led_a & ~test_q;
  assign led_drive_b   = fire_led_b & ~test_q;
  assign active_chan_a = ~seq_one & opt_q[OPT_ACT_A_POS];
  assign active_chan_b = ~seq_one & opt_q[OPT_ACT_B_POS];
  assign offset_invert = offs_inv_q;
  assign test_pulse    = test_q & ~seq_one;
  assign level_sel = fire_led_a ? {chan_a_level_high, chan_a_level_low}
                                : {chan_b_level_high, chan_b_level_low};
  assign test_current_ua = ~test_pulse         ? 5'h00 :
                           (level_sel == 2'h0) ? TEST_UA_0 :
                           (level_sel == 2'h1) ? TEST_UA_1 :
                           (level_sel == 2'h2) ? TEST_UA_2 : TEST_UA_3;

  assign status_byte = {invalid_q, power_mode, 3'h0,
                        (power_mode != 2'h0), 1'b0};

  // ------------------------------------------------------------------
  // measurement cycle and ready pin
  // ------------------------------------------------------------------
  logic [15:0] tmr_q;
  logic [15:0] min_cyc;
  logic        ready_q;
  logic        done_seen_q;
  logic        cycle_end;

  assign min_cyc   = diag_run_q ? 16'(DIAG_MIN) : (seq_one ? 16'(SEQ1_MIN) : 16'(SEQ2_MIN));
  assign cycle_end = (state_q == MSR_CONVERT) & (done_seen_q | conv_done) &
                     ~autozero_busy & (tmr_q >= min_cyc);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MSR_IDLE:    if (take_meas | take_diag) state_d = MSR_DELAY;
      MSR_DELAY:   if (tmr_q >= 16'(CS_DR_CYC - 1)) state_d = MSR_CONVERT;
      MSR_CONVERT: if (cycle_end) state_d = MSR_IDLE;
      default:     state_d = MSR_IDLE;
    endcase
    if (cs_rise & is_reset) begin
      state_d = MSR_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q     <= MSR_IDLE;
      tmr_q       <= 16'h0000;
      ready_q     <= 1'b1;
      done_seen_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (state_d != state_q) begin
        tmr_q <= 16'h0000;
      end else if (tmr_q != 16'hFFFF) begin
        tmr_q <= tmr_q + 16'h0001;
      end
      ready_q     <= (state_d != MSR_CONVERT);
      done_seen_q <= (state_q == MSR_CONVERT) & (done_seen_q | conv_done);
    end
  end

  assign data_ready_pin = ready_q;

  // ------------------------------------------------------------------
  // frame assembly with closing-up and CRC
  // ------------------------------------------------------------------
  logic [15:0] words [6];
  logic [5:0]  word_en;
  logic [7:0]  build [FRAME_MAX];
  logic [3:0]  build_len;

  always_comb begin
    if (seq_one) begin
      words[0] = res_die_temp;
      words[1] = res_amb_c;
      words[2] = res_amb_d;
      words[3] = res_reserved;
      words[4] = res_supply;
      words[5] = 16'h0000;
      word_en  = {1'b0, supply_monitor_gate, 1'b1, ambient_d_gate,
                  ambient_c_gate, die_temp_gate};
    end else begin
      words[0] = res_dc_a;
      words[1] = res_dc_b;
      words[2] = res_supply;
      words[3] = res_act_a;
      words[4] = res_act_b;
      words[5] = res_led_temp;
      word_en  = {led_heat_sense_gate, active_chan_b & active_b_gate,
                  active_chan_a & active_a_gate, supply_monitor_gate,
                  active_chan_b & active_b_gate, active_chan_a & active_a_gate};
    end
    if (diag_run_q) begin
      word_en = 6'h00;
    end
  end

  always_comb begin
    logic [3:0] n;
    logic [7:0] c;
    n = 4'h0;
    c = CRC_INIT;
    for (int i = 0; i < FRAME_MAX; i++) begin
      build[i] = 8'h00;
    end
    for (int w = 0; w < 6; w++) begin
      if (word_en[w]) begin
        build[n]        = words[w][15:8];
        build[n + 4'h1] = words[w][7:0];
        n               = n + 4'h2;
      end
    end
    for (int i = 0; i < FRAME_MAX - 1; i++) begin
      if (4'(i) < n) begin
        c = c ^ build[i];
        for (int b = 0; b < 8; b++) begin
          c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
      end
    end
    build[n]  = c;
    build_len = n + 4'h1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_len_q <= 4'h1;
      for (int i = 0; i < FRAME_MAX; i++) begin
        frame_q[i] <= 8'h00;
      end
    end else if (clk_en) begin
      if (readout_end | (cs_rise & is_reset)) begin
        frame_len_q <= 4'h1;
        for (int i = 0; i < FRAME_MAX; i++) begin
          frame_q[i] <= 8'h00;
        end
      end else if (cycle_end) begin
        frame_len_q <= build_len;
        for (int i = 0; i < FRAME_MAX; i++) begin
          frame_q[i] <= build[i];
        end
      end
    end
  end

endmodule

// ==== sim/msr_measure_readout_properties.sv ====
// msr_measure_readout_properties: port-level checks of the command block
`timescale 1ns/1ps

module msr_measure_readout_properties
  import msr_pkg::*;
(
  // system and link
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       spi_cs_n,
  input wire logic       spi_miso,
  input wire logic       spi_miso_oe,
  input wire logic       data_ready_pin,
  // configuration
  input wire logic [1:0] power_mode,
  input wire logic       autozero_busy,
  input wire logic       chan_a_level_high,
  input wire logic       chan_a_level_low,
  input wire logic       chan_b_level_high,
  input wire logic       chan_b_level_low,
  // front end control
  input wire logic       meas_start,
  input wire logic       seq_one,
  input wire logic       fire_led_a,
  input wire logic       fire_led_b,
  input wire logic       led_drive_a,
  input wire logic       led_drive_b,
  input wire logic       active_chan_a,
  input wire logic       active_chan_b,
  input wire logic       test_pulse,
  input wire logic [4:0] test_current_ua,
  input wire logic       chip_reset_pulse
);

  // ------------------------------------------------------------------
  // helpers and assertions
  // ------------------------------------------------------------------
  logic       cr_q;
  logic [4:0] amp_a;
  logic [4:0] amp_b;

  assign amp_a = 5'h05 + {chan_a_level_high, chan_a_level_low, 3'h0};
  assign amp_b = 5'h05 + {chan_b_level_high, chan_b_level_low, 3'h0};

  // a chip reset may end a cycle early; remember it until the next start
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cr_q <= 1'b0;
    end else if (chip_reset_pulse || meas_start) begin
      cr_q <= chip_reset_pulse;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_ready_hold: assert property (meas_start |-> data_ready_pin [*8])
    else $error("ready dropped too soon after start");
  a_ready_drop: assert property (meas_start |-> ##[8:30] !data_ready_pin)
    else $error("ready did not drop after start");
  a_ready_wait: assert property ($rose(data_ready_pin) && !cr_q && !chip_reset_pulse
    |-> !$past(autozero_busy)) else $error("ready rose during auto-zero");
  a_start_locked: assert property (meas_start |-> $past(data_ready_pin))
    else $error("start accepted while ready low");
  a_start_mode: assert property (meas_start |-> power_mode == MODE_NORMAL)
    else $error("start accepted outside normal mode");
  a_led_drive: assert property (led_drive_a == (fire_led_a && !test_pulse)
    && led_drive_b == (fire_led_b && !test_pulse)) else $error("led drive wrong");
  a_seq_one_quiet: assert property (seq_one
    |-> !(fire_led_a || fire_led_b || active_chan_a || active_chan_b))
    else $error("sequence one with channel options set");
  a_test_level: assert property (meas_start ##1 test_pulse
    |-> test_current_ua == (fire_led_a ? amp_a : amp_b)) else $error("test amplitude wrong");
  a_test_off: assert property (!test_pulse |-> test_current_ua == 5'h00)
    else $error("test current without test pulse");
  a_link_idle: assert property (spi_miso_oe == !spi_cs_n && (!spi_cs_n || !spi_miso))
    else $error("miso driven while deselected");

  c_seq_one: cover property (meas_start ##1 seq_one);
  c_test: cover property (meas_start ##1 test_pulse);
  c_reset_cmd: cover property (chip_reset_pulse);

endmodule

bind msr_measure_readout msr_measure_readout_properties i_msr_measure_readout_properties (.*);

// ==== sim/msr_host_model.sv ====
// msr_host_model: spi master standing in for the host controller
`timescale 1ns/1ps

module msr_host_model (
  // spi link
  output logic       spi_sclk,
  output logic       spi_cs_n,
  output logic       spi_mosi,
  input wire logic   spi_miso
);

  // ------------------------------------------------------------------
  // frame transfer
  // ------------------------------------------------------------------
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic xfer(input int n, input logic [7:0] tx [16], output logic [7:0] rx [16]);
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        spi_mosi = tx[i][b];
        #3;
        rx[i][b] = spi_miso;
        spi_sclk = 1'b1;
        #3;
        spi_sclk = 1'b0;
      end
    end
    #3;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask

endmodule

// ==== sim/testbench.sv ====
// testbench: command and read-out checks of the measurement block
`timescale 1ns/1ps

module testbench;
  import msr_pkg::*;

  // ------------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------------
  logic        clk_sys    = 1'b0;
  logic        resetn;
  logic [1:0]  power_mode = 2'h2;
  logic [6:0]  gate       = 7'h7F;
  logic [3:0]  level      = 4'h0;
  logic        az_busy    = 1'b0;
  logic        conv_done  = 1'b1;
  logic        spi_sclk;
  logic        spi_cs_n;
  logic        spi_mosi;
  logic        spi_miso;
  logic        data_ready_pin;
  logic        meas_start;
  logic        chip_reset_pulse;
  logic        fire_led_a;
  logic        led_drive_a;
  logic        offset_invert;
  logic        test_pulse;
  logic [4:0]  test_current_ua;
  logic [15:0] res [10];
  logic [7:0]  tx [16];
  logic [7:0]  rx [16];
  logic [4:0]  amp [4] = '{TEST_UA_0, TEST_UA_1, TEST_UA_2, TEST_UA_3};
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          n_start    = 0;
  int          n_cr       = 0;

  always #25 clk_sys = ~clk_sys;

  msr_measure_readout #(.SEQ1_MIN(50), .SEQ2_MIN(50), .DIAG_MIN(50), .CRC_POLY(8'h07))
  i_msr_measure_readout (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(),
    .data_ready_pin(data_ready_pin), .power_mode(power_mode), .die_temp_gate(gate[0]),
    .ambient_c_gate(gate[1]), .ambient_d_gate(gate[2]), .supply_monitor_gate(gate[3]),
    .active_a_gate(gate[4]), .active_b_gate(gate[5]), .led_heat_sense_gate(gate[6]),
    .chan_a_level_high(level[3]), .chan_a_level_low(level[2]),
    .chan_b_level_high(level[1]), .chan_b_level_low(level[0]),
    .meas_start(meas_start), .diag_start(), .seq_one(), .fire_led_a(fire_led_a),
    .fire_led_b(), .led_drive_a(led_drive_a), .led_drive_b(), .active_chan_a(),
    .active_chan_b(), .offset_invert(offset_invert), .test_pulse(test_pulse),
    .test_current_ua(test_current_ua), .chip_reset_pulse(chip_reset_pulse),
    .conv_done(conv_done), .autozero_busy(az_busy), .res_die_temp(res[0]), .res_amb_c(res[1]),
    .res_amb_d(res[2]), .res_reserved(res[3]), .res_supply(res[4]), .res_dc_a(res[5]),
    .res_dc_b(res[6]), .res_act_a(res[7]), .res_act_b(res[8]), .res_led_temp(res[9])
  );

  msr_host_model i_msr_host_model (
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
  );

  always @(posedge clk_sys) begin
    n_start <= n_start + int'(meas_start === 1'b1);
    n_cr    <= n_cr + int'(chip_reset_pulse === 1'b1);
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // even parity, unused option bits left zero
  function automatic logic [7:0] opt(input logic [6:0] m);
    return {m, ^m};
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r = c ^ d;
    for (int k = 0; k < 8; k++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  task automatic cmd(input logic [7:0] c, input logic [7:0] o);
    tx[0] = c;
    tx[1] = o;
    i_msr_host_model.xfer(2, tx, rx);
    repeat (5) @(posedge clk_sys);
  endtask

  task automatic wait_rdy(input logic v, input int lim);
    int k = 0;
    while (data_ready_pin !== v && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    chk({7'h0, data_ready_pin}, {7'h0, v});
  endtask

  // read-out: status, echo, stored words msb first, crc, then filler
  task automatic frame(input logic [7:0] st, input logic [15:0] w [6], input int nw);
    logic [7:0] crc = CRC_INIT;
    logic [7:0] b;
    tx = '{default: 8'h00};
    tx[0] = CMD_START_READ;
    i_msr_host_model.xfer(2 * nw + 4, tx, rx);
    chk(rx[0], st);
    chk(rx[1], CMD_START_READ);
    for (int i = 0; i < 2 * nw; i++) begin
      b = i[0] ? w[i / 2][7:0] : w[i / 2][15:8];
      chk(rx[i + 2], b);
      crc = crc8(crc, b);
    end
    chk(rx[2 * nw + 2], crc);
    chk(crc8(crc, rx[2 * nw + 2]), 8'h00);
    chk(rx[2 * nw + 3], 8'h00);
    repeat (5) @(posedge clk_sys);
  endtask

  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  // the tests need some 900 cycles; this is over twenty times that
  initial begin
    #1_000_000;
    n_mismatch++;
    results();
  end

  initial begin
    resetn <= 1'b0;
    foreach (res[i]) res[i] = 16'h2468 + 16'h1357 * 16'(i);
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    gate <= 7'h7B;
    cmd(8'hD0, opt(7'h40));
    chk(8'(n_start), 8'd1);
    wait_rdy(1'b0, 40);
    repeat (25) @(posedge clk_sys);
    chk({7'h0, data_ready_pin}, 8'h00);
    wait_rdy(1'b1, 200);
    frame(8'h42, '{res[0], res[1], res[3], res[4], 16'h0, 16'h0}, 4);
    frame(8'h42, '{default: 16'h0}, 0);
    gate <= 7'h77;
    for (int k = 0; k < 4; k++) begin
      level <= {k[1:0], ~k[1:0]};
      cmd(8'hD3, opt(7'h0A));
      chk({3'h0, test_current_ua}, {3'h0, amp[k]});
      chk({6'h0, led_drive_a, fire_led_a}, 8'h01);
      chk({6'h0, test_pulse, offset_invert}, 8'h03);
      wait_rdy(1'b0, 40);
      wait_rdy(1'b1, 200);
    end
    frame(8'h42, '{res[5], res[7], res[9], 16'h0, 16'h0, 16'h0}, 3);
    az_busy   <= 1'b1;
    conv_done <= 1'b0;
    cmd(8'hD0, 8'h80);
    chk(8'(n_start), 8'd5);
    cmd(8'hD0, opt(7'h40));
    chk(rx[0], 8'hC2);
    wait_rdy(1'b0, 40);
    cmd(CMD_START_READ, 8'h00);
    repeat (200) @(posedge clk_sys);
    chk({7'h0, data_ready_pin}, 8'h00);
    az_busy <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk({7'h0, data_ready_pin}, 8'h00);
    conv_done <= 1'b1;
    wait_rdy(1'b1, 20);
    cmd(8'h00, 8'h00);
    chk(rx[0], 8'hC2);
    cmd(8'hD0, opt(7'h40));
    wait_rdy(1'b0, 40);
    cmd(CMD_CHIP_RESET, 8'h00);
    chk(8'(n_cr), 8'd1);
    wait_rdy(1'b1, 2);
    frame(8'h42, '{default: 16'h0}, 0);
    cmd(CMD_START_DIAG, 8'h00);
    wait_rdy(1'b0, 40);
    cmd(8'hD0, opt(7'h40));
    wait_rdy(1'b1, 200);
    frame(8'hC2, '{default: 16'h0}, 0);
    power_mode <= 2'h1;
    cmd(8'hD0, opt(7'h40));
    cmd(CMD_START_READ, 8'h00);
    chk(rx[0], 8'hA2);
    cmd(8'h00, 8'h00);
    chk(rx[0], 8'hA2);
    chk(8'(n_start), 8'd7);
    chk({7'h0, data_ready_pin}, 8'h01);
    results();
  end

endmodule
